// *** rtl/gpio_sync2.sv ***
// two-flop synchroniser for levels arriving from pins
`timescale 1ns/100ps
`default_nettype none
module gpio_sync2 #(
   parameter int WIDTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

// *** rtl/lcd_gpio_defines.svh ***
// constants for the lcd-shared gpio port: offsets, fields, reset values
`ifndef LCD_GPIO_DEFINES_SVH
`define LCD_GPIO_DEFINES_SVH

`define GPIO_ADDR_W 8
`define GPIO_IDX_W 6
`define GPIO_OFS_PIN_VALUE 8'h00
`define GPIO_OFS_OUT_LATCH 8'h04
`define GPIO_OFS_DIRECTION 8'h08
`define GPIO_OFS_SHARED_PU 8'h0c
`define GPIO_OFS_SEG_LOW 8'h10

`define GPIO_RST_LATCH 8'h00
`define GPIO_RST_DIR 8'hff
`define GPIO_RST_SEG 8'h00
`define GPIO_RST_PU 1'b0
`define GPIO_ALL_ONES 8'hff
`define GPIO_ALL_ZERO 8'h00

`define GPIO_PU_THIS_BIT 7
`define GPIO_PU_NEXT_BIT 6
`define GPIO_PU_THIRD_BIT 5
`define GPIO_OTHER_PINS_MSB 4

`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10
`define AXI_DATA_ZERO 32'h0000_0000

`endif

// *** rtl/lcd_gpio_pkg.sv ***
// types shared by the lcd-shared gpio port
package lcd_gpio_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [4:0] other_pins_t;
   typedef logic [31:0] word_t;
   typedef logic [7:0] addr_t;
   typedef logic [1:0] resp_t;
   typedef enum logic [1:0] {
      bus_idle = 2'b01,
      bus_resp = 2'b10
   } bus_state_e;
endpackage

// *** rtl/lcd_shared_gpio_port_d.sv ***
// lcd-shared 8-bit gpio port with axi4-lite register access
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "lcd_gpio_defines.svh"

// Summary of operation
// R01 - eight bidirectional pins, one bit per register
// R02 - direction 0 drives latch, 1 reads pin
// R03 - reset leaves every pin a digital input
// R04 - shared bit 7 enables all eight pull-ups
// R05 - output pins never get a pull-up
// R06 - reset leaves every pull-up disabled
// R07 - segment enable bit n claims pin n
// R08 - segment owner disables port output and input
// R09 - segment drive overrides the direction bit
// R10 - shared register: three pull-ups, five pin values
// R11 - pin-value write loads latch; latch reads latch
module lcd_shared_gpio_port_d #(
   parameter bit SMALL_PACKAGE = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire lcd_gpio_pkg::addr_t s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire lcd_gpio_pkg::word_t s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output lcd_gpio_pkg::resp_t s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire lcd_gpio_pkg::addr_t s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output lcd_gpio_pkg::word_t s_axi_rdata,
   output lcd_gpio_pkg::resp_t s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire lcd_gpio_pkg::byte_t port_pin_in,
   output lcd_gpio_pkg::byte_t port_pin_out,
   output lcd_gpio_pkg::byte_t port_pin_oe,
   output lcd_gpio_pkg::byte_t pin_pullup_on,
   output lcd_gpio_pkg::byte_t lcd_segment_drive,
   input wire lcd_gpio_pkg::other_pins_t shared_port_pins_in,
   output logic pullup_enable_next_port,
   output logic pullup_enable_third_port
);
   import lcd_gpio_pkg::*;

   function automatic logic is_reg(input addr_t a, input addr_t ofs);
      is_reg = (a[`GPIO_ADDR_W-1:2] == ofs[`GPIO_ADDR_W-1:2]);
   endfunction

   function automatic logic is_mapped(input addr_t a);
      is_mapped = is_reg(a, `GPIO_OFS_PIN_VALUE) | is_reg(a, `GPIO_OFS_OUT_LATCH)
         | is_reg(a, `GPIO_OFS_DIRECTION) | is_reg(a, `GPIO_OFS_SHARED_PU)
         | is_reg(a, `GPIO_OFS_SEG_LOW);
   endfunction

   // register state
   byte_t latch_q;
   byte_t dir_q;
   byte_t seg_q;
   logic pu_this_q;
   logic pu_next_q;
   logic pu_third_q;

   // pin-facing flops
   byte_t pin_out_q;
   byte_t pin_oe_q;
   byte_t pullup_q;
   byte_t seg_drive_q;
   logic pu_next_out_q;
   logic pu_third_out_q;

   // synchronised pin levels
   logic [12:0] pins_sync;
   byte_t pin_level;
   other_pins_t other_level;

   gpio_sync2 #(.WIDTH(13)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({shared_port_pins_in, port_pin_in}),
      .sync_out(pins_sync)
   );
   assign pin_level = pins_sync[7:0];
   assign other_level = pins_sync[12:8];

   // write channel
   bus_state_e wr_state_q;
   logic awready_q;
   logic wready_q;
   logic aw_have_q;
   logic w_have_q;
   addr_t aw_addr_q;
   byte_t w_byte_q;
   logic w_lane0_q;
   resp_t bresp_q;

   wire aw_fire = s_axi_awvalid & awready_q;
   wire w_fire = s_axi_wvalid & wready_q;
   wire aw_ok = aw_have_q | aw_fire;
   wire w_ok = w_have_q | w_fire;
   wire do_write = aw_ok & w_ok & (wr_state_q == bus_idle);
   wire addr_t wr_addr = aw_have_q ? aw_addr_q : s_axi_awaddr;
   wire byte_t wr_byte = w_have_q ? w_byte_q : s_axi_wdata[7:0];
   wire wr_lane0 = w_have_q ? w_lane0_q : s_axi_wstrb[0];
   wire wr_hit = do_write & wr_lane0;
   // writes through either name land in the latch
   wire wr_latch = wr_hit & (is_reg(wr_addr, `GPIO_OFS_PIN_VALUE)
      | is_reg(wr_addr, `GPIO_OFS_OUT_LATCH)); // [R11]
   wire wr_dir = wr_hit & is_reg(wr_addr, `GPIO_OFS_DIRECTION);
   wire wr_pu = wr_hit & is_reg(wr_addr, `GPIO_OFS_SHARED_PU);
   wire wr_seg = wr_hit & is_reg(wr_addr, `GPIO_OFS_SEG_LOW);
   wire wr_done = (wr_state_q == bus_resp) & s_axi_bready;
   wire aw_have_d = aw_ok & ~do_write;
   wire w_have_d = w_ok & ~do_write;
   wire bvalid_d = do_write | ((wr_state_q == bus_resp) & ~s_axi_bready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= bus_idle;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_byte_q <= '0;
         w_lane0_q <= 1'b0;
         bresp_q <= `AXI_RESP_OKAY;
      end else begin
         if (do_write)
            wr_state_q <= bus_resp;
         else if (wr_done)
            wr_state_q <= bus_idle;
         awready_q <= ~aw_have_d & ~bvalid_d;
         wready_q <= ~w_have_d & ~bvalid_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         if (aw_fire)
            aw_addr_q <= s_axi_awaddr;
         if (w_fire) begin
            w_byte_q <= s_axi_wdata[7:0];
            w_lane0_q <= s_axi_wstrb[0];
         end
         if (do_write)
            bresp_q <= is_mapped(wr_addr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = wr_state_q[1];
   assign s_axi_bresp = bresp_q;

   // register file; pins reset to inputs with pull-ups off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_q <= `GPIO_RST_LATCH;
         dir_q <= `GPIO_RST_DIR; // [R03]
         seg_q <= `GPIO_RST_SEG;
         pu_this_q <= `GPIO_RST_PU; // [R06]
         pu_next_q <= `GPIO_RST_PU;
         pu_third_q <= `GPIO_RST_PU;
      end else begin
         if (wr_latch)
            latch_q <= wr_byte; // [R01] [R11]
         if (wr_dir)
            dir_q <= wr_byte; // [R02]
         if (wr_seg)
            seg_q <= wr_byte; // [R07]
         if (wr_pu) begin
            pu_this_q <= wr_byte[`GPIO_PU_THIS_BIT]; // [R04]
            pu_next_q <= wr_byte[`GPIO_PU_NEXT_BIT]; // [R10]
            // bit does not exist on the small package
            pu_third_q <= wr_byte[`GPIO_PU_THIRD_BIT] & ~SMALL_PACKAGE; // [R10]
         end
      end
   end

   // pin muxing; segment ownership beats direction and pull-up
   wire byte_t port_owned = ~seg_q; // [R08]
   wire byte_t drive_en = ~dir_q & port_owned; // [R02] [R09]
   wire byte_t pullup_d = ({8{pu_this_q}} & dir_q & port_owned); // [R04] [R05] [R08]
   // input path is dead while the segment owns the pin
   wire byte_t pin_read = pin_level & port_owned; // [R08]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out_q <= `GPIO_RST_LATCH;
         pin_oe_q <= `GPIO_ALL_ZERO; // [R03]
         pullup_q <= `GPIO_ALL_ZERO; // [R06]
         seg_drive_q <= `GPIO_RST_SEG;
         pu_next_out_q <= `GPIO_RST_PU;
         pu_third_out_q <= `GPIO_RST_PU;
      end else begin
         pin_out_q <= latch_q & port_owned; // [R02]
         pin_oe_q <= drive_en; // [R02] [R09]
         pullup_q <= pullup_d; // [R05]
         seg_drive_q <= seg_q; // [R07]
         pu_next_out_q <= pu_next_q;
         pu_third_out_q <= pu_third_q;
      end
   end

   assign port_pin_out = pin_out_q;
   assign port_pin_oe = pin_oe_q;
   assign pin_pullup_on = pullup_q;
   assign lcd_segment_drive = seg_drive_q;
   assign pullup_enable_next_port = pu_next_out_q;
   assign pullup_enable_third_port = pu_third_out_q;

   // read channel
   bus_state_e rd_state_q;
   logic arready_q;
   word_t rdata_q;
   resp_t rresp_q;

   wire ar_fire = s_axi_arvalid & arready_q;
   wire rd_done = (rd_state_q == bus_resp) & s_axi_rready;
   wire byte_t shared_rd = {pu_this_q, pu_next_q, pu_third_q, other_level}; // [R10]
   wire byte_t rd_byte =
      is_reg(s_axi_araddr, `GPIO_OFS_PIN_VALUE) ? pin_read :
      is_reg(s_axi_araddr, `GPIO_OFS_OUT_LATCH) ? latch_q : // [R11]
      is_reg(s_axi_araddr, `GPIO_OFS_DIRECTION) ? dir_q :
      is_reg(s_axi_araddr, `GPIO_OFS_SHARED_PU) ? shared_rd :
      is_reg(s_axi_araddr, `GPIO_OFS_SEG_LOW) ? seg_q : `GPIO_ALL_ZERO;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q <= bus_idle;
         arready_q <= 1'b0;
         rdata_q <= `AXI_DATA_ZERO;
         rresp_q <= `AXI_RESP_OKAY;
      end else begin
         arready_q <= (rd_state_q == bus_idle) & ~ar_fire | rd_done;
         if (ar_fire) begin
            rd_state_q <= bus_resp;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= is_mapped(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         end else if (rd_done) begin
            rd_state_q <= bus_idle;
         end
      end
   end

   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rd_state_q[1];
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // checks
   property p_latch_to_pin;
      @(posedge aclk) disable iff (!aresetn)
      wr_latch && !wr_seg && seg_q == `GPIO_ALL_ZERO
         |-> ##2 port_pin_out == $past(wr_byte, 2);
   endproperty
   a_latch_to_pin: assert property (p_latch_to_pin) // [R01]
      else $error("latch write did not reach the pins");

   property p_dir_drives;
      @(posedge aclk) disable iff (!aresetn)
      ##1 port_pin_oe == ~($past(dir_q) | $past(seg_q));
   endproperty
   a_dir_drives: assert property (p_dir_drives) // [R02]
      else $error("output enable does not follow direction");

   property p_reset_inputs;
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> port_pin_oe == `GPIO_ALL_ZERO && dir_q == `GPIO_RST_DIR;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs) // [R03]
      else $error("pins not inputs after reset");

   property p_shared_enable;
      @(posedge aclk) disable iff (!aresetn)
      pin_pullup_on != `GPIO_ALL_ZERO |-> $past(pu_this_q);
   endproperty
   a_shared_enable: assert property (p_shared_enable) // [R04]
      else $error("pull-up on while shared enable clear");

   property p_no_pullup_on_output;
      @(posedge aclk) disable iff (!aresetn)
      ##1 (pin_pullup_on & ~$past(dir_q)) == `GPIO_ALL_ZERO;
   endproperty
   a_no_pullup_on_output: assert property (p_no_pullup_on_output) // [R05]
      else $error("pull-up on an output pin");

   property p_reset_pullups;
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> pin_pullup_on == `GPIO_ALL_ZERO && !pu_this_q;
   endproperty
   a_reset_pullups: assert property (p_reset_pullups) // [R06]
      else $error("pull-ups enabled after reset");

   property p_seg_select;
      @(posedge aclk) disable iff (!aresetn)
      wr_seg |-> ##2 lcd_segment_drive == $past(wr_byte, 2);
   endproperty
   a_seg_select: assert property (p_seg_select) // [R07]
      else $error("segment enable not applied");

   property p_seg_exclusive;
      @(posedge aclk) disable iff (!aresetn)
      (port_pin_oe & lcd_segment_drive) == `GPIO_ALL_ZERO
         && (pin_pullup_on & lcd_segment_drive) == `GPIO_ALL_ZERO;
   endproperty
   a_seg_exclusive: assert property (p_seg_exclusive) // [R08]
      else $error("port function active on a segment pin");

   property p_seg_over_dir;
      @(posedge aclk) disable iff (!aresetn)
      (seg_q & ~dir_q) != `GPIO_ALL_ZERO |-> ##1 (port_pin_oe & $past(seg_q)) == `GPIO_ALL_ZERO;
   endproperty
   a_seg_over_dir: assert property (p_seg_over_dir) // [R09]
      else $error("direction bit drove a segment pin");

   property p_small_pkg;
      @(posedge aclk) disable iff (!aresetn)
      SMALL_PACKAGE |-> !pu_third_q && !pullup_enable_third_port;
   endproperty
   a_small_pkg: assert property (p_small_pkg) // [R10]
      else $error("missing pull-up bit became set");

   property p_pin_value_write;
      @(posedge aclk) disable iff (!aresetn)
      wr_hit && is_reg(wr_addr, `GPIO_OFS_PIN_VALUE) |-> ##1 latch_q == $past(wr_byte);
   endproperty
   a_pin_value_write: assert property (p_pin_value_write) // [R11]
      else $error("pin-value write missed the latch");
endmodule
`default_nettype wire

// *** tb/lcd_shared_gpio_port_d_tb.sv ***
// self-checking bench for the lcd-shared gpio port
`timescale 1ns/100ps
`default_nettype none
`include "lcd_gpio_defines.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD %0t got %h want %h", $time, a, b); end end
module lcd_shared_gpio_port_d_tb;
   import lcd_gpio_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0;
   addr_t awaddr = 0, araddr = 0;
   word_t wdata = 0, rdata, w, d;
   logic [3:0] wstrb = 0;
   logic awready, wready, bvalid, arready, rvalid, pu_nx, pu_th, pe, pu_nx_s, pu_th_s;
   resp_t bresp, rresp, r;
   byte_t lvl, pout, poe, pu, sdrv, ev = 0, ee = 0, l, dr, sg, m, ex;
   logic [1:0] nt;
   other_pins_t oth = 0;
   int n_errors = 0, n_compared = 0, cyc = 0;
   word_t seed = 32'h2b31f785;

   lcd_shared_gpio_port_d dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_pin_in(lvl),
      .port_pin_out(pout), .port_pin_oe(poe), .pin_pullup_on(pu),
      .lcd_segment_drive(sdrv), .shared_port_pins_in(oth),
      .pullup_enable_next_port(pu_nx), .pullup_enable_third_port(pu_th));
   pin_model pm_u (.aclk(aclk), .pin_out(pout), .pin_oe(poe), .pu_on(pu),
      .ext_val(ev), .ext_en(ee), .level(lvl));
   // small-package twin follows the same bus traffic; only its next-port and third-port pull-up enables are watched
   lcd_shared_gpio_port_d #(.SMALL_PACKAGE(1'b1)) small_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
      .s_axi_rvalid(), .s_axi_rready(rready), .port_pin_in(lvl),
      .port_pin_out(), .port_pin_oe(), .pin_pullup_on(),
      .lcd_segment_drive(), .shared_port_pins_in(oth),
      .pullup_enable_next_port(pu_nx_s), .pullup_enable_third_port(pu_th_s));

   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      // the whole run needs well under this many cycles
      if (cyc > 8000) begin
         n_errors++;
         stop_test();
      end
   end

   function automatic word_t nx();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   // expected pin-value read: segment pins read 0, outputs read the latch
   function automatic byte_t exp_pin(input byte_t lat, dir, seg, en, val, input logic p);
      return ~seg & ((~dir & lat) | (dir & en & val) | (dir & ~en & {8{p}}));
   endfunction

   task automatic stop_test();
      if (n_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic wr(input addr_t a, input byte_t v, input logic s, output resp_t rs);
      logic ad, wd;
      ad = 0;
      wd = 0;
      awaddr <= a;
      wdata <= {24'h0, v};
      wstrb <= {3'h0, s};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input addr_t a, output word_t v, output resp_t rs);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      v = rdata;
      rs = rresp;
      // rready stays high: a back-to-back read would otherwise drop and raise it in one step
   endtask

   task automatic ck(input addr_t a, input byte_t e);
      word_t v;
      resp_t rs;
      rd(a, v, rs);
      `CHK(rs, `AXI_RESP_OKAY);
      `CHK(v, {24'h0, e});
   endtask

   task automatic do_reset(input int n);
      aresetn <= 1'b0;
      repeat (n) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      `CHK(poe, 8'h00);
      `CHK(pu, 8'h00);
      `CHK(sdrv, 8'h00);
      `CHK({pu_nx, pu_th}, 2'b00);
      ck(`GPIO_OFS_DIRECTION, 8'hff);
      ck(`GPIO_OFS_SHARED_PU, {3'h0, oth});
      ck(`GPIO_OFS_OUT_LATCH, `GPIO_RST_LATCH);
      ck(`GPIO_OFS_SEG_LOW, `GPIO_RST_SEG);
      `CHK({pu_nx_s, pu_th_s}, 2'b00);
   endtask

   initial begin
      do_reset(12);
      rd(8'h14, d, r);
      `CHK({r, d}, {`AXI_RESP_SLVERR, `AXI_DATA_ZERO});
      wr(8'hfc, 8'hff, 1'b1, r);
      `CHK(r, `AXI_RESP_SLVERR);
      wr(`GPIO_OFS_OUT_LATCH, 8'hff, 1'b0, r);
      ck(`GPIO_OFS_OUT_LATCH, 8'h00);
      for (int i = 0; i < 40; i++) begin
         w = nx();
         l = w[7:0];
         dr = w[15:8];
         sg = w[23:16];
         pe = w[24];
         nt = w[26:25];
         // corners: segment owns all outputs, then pull-up against outputs and inputs
         if (i < 3) sg = (i == 0) ? 8'hff : 8'h00;
         if (i < 3) dr = (i == 2) ? 8'hff : 8'h00;
         if (i == 1 || i == 2) pe = 1'b1;
         w = nx();
         ev <= w[7:0];
         ee <= w[15:8] & dr & ~sg;
         oth <= w[20:16];
         wr(i[0] ? `GPIO_OFS_PIN_VALUE : `GPIO_OFS_OUT_LATCH, l, 1'b1, r);
         wr(`GPIO_OFS_DIRECTION, dr, 1'b1, r);
         wr(`GPIO_OFS_SEG_LOW, sg, 1'b1, r);
         wr(`GPIO_OFS_SHARED_PU, {pe, nt, 5'h1f}, 1'b1, r);
         repeat (4) @(posedge aclk);
         `CHK(poe, ~dr & ~sg);
         `CHK(pout, l & ~sg);
         `CHK(pu, {8{pe}} & dr & ~sg);
         `CHK(sdrv, sg);
         `CHK({pu_nx, pu_th}, nt);
         `CHK({pu_nx_s, pu_th_s}, {nt[1], 1'b0});
         ck(`GPIO_OFS_OUT_LATCH, l);
         ck(`GPIO_OFS_DIRECTION, dr);
         ck(`GPIO_OFS_SEG_LOW, sg);
         ck(`GPIO_OFS_SHARED_PU, {pe, nt, oth});
         // floating inputs without pull-up have no defined level
         m = sg | ~dr | ee | ({8{pe}} & dr);
         ex = exp_pin(l, dr, sg, ee, ev, pe);
         rd(`GPIO_OFS_PIN_VALUE, d, r);
         `CHK(d[7:0] & m, ex & m);
      end
      do_reset(3);
      stop_test();
   end
endmodule
`default_nettype wire

// *** tb/pin_model.sv ***
// far-side pin model: external drivers, weak pull-ups, floating lines
`timescale 1ns/100ps
`default_nettype none
module pin_model (
   input wire logic aclk,
   input wire lcd_gpio_pkg::byte_t pin_out,
   input wire lcd_gpio_pkg::byte_t pin_oe,
   input wire lcd_gpio_pkg::byte_t pu_on,
   input wire lcd_gpio_pkg::byte_t ext_val,
   input wire lcd_gpio_pkg::byte_t ext_en,
   output var lcd_gpio_pkg::byte_t level
);
   import lcd_gpio_pkg::*;
   byte_t float_q = 8'h5a;
   // an undriven line wanders, so a stale level never passes as valid
   always @(posedge aclk) float_q <= ~float_q;
   // pull-up wins only where nobody drives the line
   assign level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pu_on | float_q));
endmodule
`default_nettype wire
